// ==== rtl/fridge_compressor_control.sv ====
module fridge_compressor_control
  import fridge_pkg::*;
#(
  parameter int START_CYC = fridge_pkg::START_WINDOW_CYC,
  parameter int GATE_CYC = fridge_pkg::GATE_PULSE_CYC,
  parameter int DOOR_TICKS = fridge_pkg::DOOR_DELAY_TICKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic timeTick,
  input wire fridge_pkg::temp_t airTemp,
  input wire logic airTempValid,
  input wire logic zeroCross,
  input wire logic doorOpen,
  output logic relayOn,
  output logic triacGate,
  output logic buzzer,
  output logic alarmLed,
  output logic compressorLed,
  output logic powerLed
);

  import fridge_pkg::*;

  localparam int WIN_W = $clog2(START_CYC + 1);
  localparam int GATE_W = $clog2(GATE_CYC + 1);
  localparam int DOOR_W = $clog2(DOOR_TICKS + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(START_CYC - 1);
  localparam logic [GATE_W-1:0] GATE_LOAD = GATE_W'(GATE_CYC);
  localparam logic [DOOR_W-1:0] DOOR_LAST = DOOR_W'(DOOR_TICKS);

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [SYNC_N-1:0] pinRaw;
  logic [SYNC_N-1:0] pinLevel;
  logic [SYNC_N-1:0] pinEdge;
  logic zcEvent;
  logic doorIsOpen;

  assign pinRaw[SYNC_ZC] = zeroCross;
  assign pinRaw[SYNC_DOOR] = doorOpen;

  pin_sync #(
    .WIDTH(SYNC_N)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .pinIn(pinRaw),
    .level(pinLevel),
    .anyEdge(pinEdge)
  );

  // the edge flag lands two enabled edges after the pin moves
  assign zcEvent = pinEdge[SYNC_ZC];
  assign doorIsOpen = pinLevel[SYNC_DOOR];

  // ******************************************************
  // temperature sample and bands
  // ******************************************************
  // the loop acts only on a fresh conversion; held value between strobes
  temp_t temp_reg;
  logic tempSeen_reg;
  logic atRangeMin;
  logic atRangeMax;
  logic belowRangeMax;
  logic overTemp;
  logic underTemp;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_reg <= RANGE_MAX;
    end else if (clkEn && airTempValid) begin
      temp_reg <= airTemp;
    end
  end

  // bands stay inert until the first conversion has landed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tempSeen_reg <= 1'b0;
    end else if (clkEn && airTempValid) begin
      tempSeen_reg <= 1'b1;
    end
  end

  assign atRangeMin = tempSeen_reg && (temp_reg <= RANGE_MIN);
  assign atRangeMax = tempSeen_reg && (temp_reg >= RANGE_MAX);
  assign belowRangeMax = tempSeen_reg && (temp_reg < RANGE_MAX);
  assign overTemp = tempSeen_reg && (temp_reg >= ALARM_MAX);
  assign underTemp = tempSeen_reg && (temp_reg <= ALARM_MIN);

  // ******************************************************
  // hysteresis demand
  // ******************************************************
  // between the two limits the demand holds its last value
  logic demand_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      demand_reg <= 1'b0;
    end else if (clkEn) begin
      if (atRangeMin) begin
        demand_reg <= 1'b0;
      end else if (atRangeMax) begin
        demand_reg <= 1'b1;
      end
    end
  end

  // ******************************************************
  // start sequence
  // ******************************************************
  comp_state_t state_reg;
  comp_state_t state_next;
  logic [WIN_W-1:0] winCnt_reg;
  logic winDone;

  assign winDone = (winCnt_reg >= WIN_LAST);

  // a drop in demand aborts the start at any step
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      COMP_IDLE: begin
        if (demand_reg) begin
          state_next = COMP_ARM;
        end
      end
      COMP_ARM: begin
        if (!demand_reg) begin
          state_next = COMP_IDLE;
        end else if (zcEvent) begin
          state_next = COMP_FIRE;
        end
      end
      COMP_FIRE: begin
        if (!demand_reg) begin
          state_next = COMP_IDLE;
        end else if (winDone) begin
          state_next = COMP_RUN;
        end
      end
      COMP_RUN: begin
        if (!demand_reg) begin
          state_next = COMP_IDLE;
        end
      end
      default: begin
        state_next = COMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= COMP_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // window counts from the first crossing, not from the relay closing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      winCnt_reg <= '0;
    end else if (clkEn) begin
      if (state_reg != COMP_FIRE) begin
        winCnt_reg <= '0;
      end else if (!winDone) begin
        winCnt_reg <= winCnt_reg + 1'b1;
      end
    end
  end

  // ******************************************************
  // relay and triac outputs
  // ******************************************************
  // relay closes before any gate pulse and stays closed through run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relayOn <= 1'b0;
    end else if (clkEn) begin
      relayOn <= (state_next != COMP_IDLE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compressorLed <= 1'b0;
    end else if (clkEn) begin
      compressorLed <= (state_next != COMP_IDLE);
    end
  end

  // a short gate pulse per crossing; the triac latches until current zero
  logic [GATE_W-1:0] gateCnt_reg;
  logic fireNow;

  assign fireNow = zcEvent && demand_reg
    && ((state_reg == COMP_ARM)
        || ((state_reg == COMP_FIRE) && !winDone));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gateCnt_reg <= '0;
    end else if (clkEn) begin
      if (fireNow) begin
        gateCnt_reg <= GATE_LOAD;
      end else if (state_next == COMP_IDLE || state_next == COMP_RUN) begin
        gateCnt_reg <= '0;
      end else if (gateCnt_reg != '0) begin
        gateCnt_reg <= gateCnt_reg - 1'b1;
      end
    end
  end

  // the gate is cut at once when the relay drops or the window closes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      triacGate <= 1'b0;
    end else if (clkEn) begin
      triacGate <= fireNow || ((gateCnt_reg > GATE_W'(1))
        && (state_next == COMP_ARM || state_next == COMP_FIRE));
    end
  end

  // ******************************************************
  // door delay on the time-base tick
  // ******************************************************
  // any close restarts the full delay, so brief openings never alarm
  logic [DOOR_W-1:0] doorCnt_reg;
  logic doorAlarm;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      doorCnt_reg <= '0;
    end else if (clkEn) begin
      if (!doorIsOpen) begin
        doorCnt_reg <= '0;
      end else if (timeTick && doorCnt_reg != DOOR_LAST) begin
        doorCnt_reg <= doorCnt_reg + 1'b1;
      end
    end
  end

  assign doorAlarm = doorIsOpen && (doorCnt_reg == DOOR_LAST);

  // ******************************************************
  // alarm enable, buzzer and indicators
  // ******************************************************
  // warm start is no fault: stay quiet until the cabinet first cools
  logic alarmsOn_reg;
  logic alarmAny;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarmsOn_reg <= 1'b0;
    end else if (clkEn && belowRangeMax) begin
      alarmsOn_reg <= 1'b1;
    end
  end

  assign alarmAny = doorAlarm || overTemp || underTemp;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buzzer <= 1'b0;
    end else if (clkEn) begin
      buzzer <= alarmsOn_reg && alarmAny;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarmLed <= 1'b0;
    end else if (clkEn) begin
      alarmLed <= alarmAny;
    end
  end

  // power indicator lights from the first enabled edge after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerLed <= 1'b0;
    end else if (clkEn) begin
      powerLed <= 1'b1;
    end
  end

endmodule

// ==== pkg/fridge_pkg.sv ====
package fridge_pkg;

  // ******************************************************
  // clock and time base
  // ******************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int START_WINDOW_MS = 40;
  localparam int START_WINDOW_CYC = (CLK_HZ / 1000) * START_WINDOW_MS;
  localparam int GATE_PULSE_US = 20;
  localparam int GATE_PULSE_CYC = (CLK_HZ / 1_000_000) * GATE_PULSE_US;
  localparam int TICK_PERIOD_MS = 1;
  localparam int DOOR_DELAY_S = 60;
  localparam int DOOR_DELAY_TICKS = (DOOR_DELAY_S * 1000) / TICK_PERIOD_MS;

  // ******************************************************
  // temperatures, signed, tenths of a degree C
  // ******************************************************
  localparam int TEMP_W = 12;
  typedef logic signed [TEMP_W-1:0] temp_t;
  localparam temp_t RANGE_MAX = 12'sh050;
  localparam temp_t RANGE_MIN = 12'sh014;
  localparam temp_t ALARM_MAX = 12'sh078;
  localparam temp_t ALARM_MIN = 12'sh000;

  // ******************************************************
  // compressor start sequence, gray coded along the path
  // ******************************************************
  typedef enum logic [1:0] {
    COMP_IDLE = 2'h0,
    COMP_ARM = 2'h1,
    COMP_FIRE = 2'h3,
    COMP_RUN = 2'h2
  } comp_state_t;

  localparam int SYNC_ZC = 0;
  localparam int SYNC_DOOR = 1;
  localparam int SYNC_N = 2;

endpackage

// ==== rtl/pin_sync.sv ====
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] anyEdge
);

  // ******************************************************
  // two-flop synchroniser plus edge detect per pin
  // ******************************************************
  // the first stage feeds only the second; edges compare stage 2 and 3
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic meta_reg;
      logic stable_reg;
      logic last_reg;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
          last_reg <= 1'b0;
        end else if (clkEn) begin
          meta_reg <= pinIn[i];
          stable_reg <= meta_reg;
          last_reg <= stable_reg;
        end
      end
      assign level[i] = stable_reg;
      assign anyEdge[i] = stable_reg ^ last_reg;
    end
  endgenerate

endmodule

// ==== testbench/fcc_asserts.sv ====
module fcc_asserts
  import fridge_pkg::*;
#(
  parameter int START_CYC = 200
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire fridge_pkg::temp_t airTemp,
  input wire logic airTempValid,
  input wire logic zeroCross,
  input wire logic relayOn,
  input wire logic triacGate,
  input wire logic buzzer,
  input wire logic alarmLed,
  input wire logic compressorLed
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN_LIM = START_CYC + 16;
  logic zcLast;
  logic [3:0] sinceZc;
  logic [8:0] winCnt;
  logic armed;
  default clocking @(posedge clk); endclocking
  // a frozen block answers nothing, so checks pause with the enable
  default disable iff (!nrst || !clkEn);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zcLast <= 1'b0;
      sinceZc <= 4'hF;
    end else begin
      zcLast <= zeroCross;
      if (zcLast != zeroCross) sinceZc <= 4'h0;
      else if (sinceZc != 4'hF) sinceZc <= sinceZc + 4'h1;
    end
  end
  // window age starts at the first pulse and saturates, never wraps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) winCnt <= 9'h000;
    else if (!relayOn) winCnt <= 9'h000;
    else if ((winCnt != 9'h000 || triacGate) && winCnt != 9'h1FF)
      winCnt <= winCnt + 9'h001;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) armed <= 1'b0;
    else if (clkEn && airTempValid && airTemp < RANGE_MAX) armed <= 1'b1;
  end
  sequence pulse_s;
    (triacGate || !relayOn) [*4] ##1 !triacGate;
  endsequence
  a_relay_hot: assert property (
    airTempValid && airTemp >= RANGE_MAX |-> ##3 relayOn)
    else $error("relay not on after hot sample");
  a_relay_cold: assert property (
    airTempValid && airTemp <= RANGE_MIN |-> ##3 !relayOn)
    else $error("relay not off after cold sample");
  a_led_relay: assert property (compressorLed == relayOn)
    else $error("compressor led differs from relay");
  a_gate_relay: assert property ($rose(triacGate) |-> relayOn)
    else $error("gate fired without relay");
  a_gate_zc: assert property (
    $rose(triacGate) |-> sinceZc inside {[1:6]})
    else $error("gate fired without a recent crossing");
  a_gate_pulse: assert property ($rose(triacGate) |-> pulse_s)
    else $error("gate pulse width wrong");
  a_gate_window: assert property (triacGate |-> winCnt < WIN_LIM)
    else $error("gate active after start window");
  a_over_led: assert property (
    airTempValid && airTemp >= ALARM_MAX |-> ##[1:3] alarmLed)
    else $error("no alarm at high temperature");
  a_under_led: assert property (
    airTempValid && airTemp <= ALARM_MIN |-> ##[1:3] alarmLed)
    else $error("no alarm at low temperature");
  a_buzz_armed: assert property (buzzer |-> armed && alarmLed)
    else $error("buzzer before alarms enabled");
endmodule

bind fridge_compressor_control fcc_asserts #(.START_CYC(START_CYC)) i_chk (
  .clk(clk), .nrst(nrst), .clkEn(clkEn), .airTemp(airTemp),
  .airTempValid(airTempValid),
  .zeroCross(zeroCross), .relayOn(relayOn), .triacGate(triacGate),
  .buzzer(buzzer), .alarmLed(alarmLed), .compressorLed(compressorLed));

// ==== testbench/zero_cross_src.sv ====
module zero_cross_src #(
  parameter int HALF = 30
) (
  input wire logic clk,
  output logic zeroCross
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial zeroCross = 1'b0;
  // mains runs free; each half cycle gives one edge, rising or falling
  always @(posedge clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) zeroCross <= #2 ~zeroCross;
  end
endmodule

// ==== testbench/fridge_compressor_control_test.sv ====
module fridge_compressor_control_test;
  import fridge_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  localparam int TB_START = 200;
  localparam int TB_HALF = 30;
  localparam int EXP_GATES = 1 + (TB_START - 1) / TB_HALF;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic timeTick = 1'b0;
  temp_t airTemp = 12'sh000;
  logic airTempValid = 1'b0;
  logic doorOpen = 1'b0;
  logic zeroCross, relayOn, triacGate, buzzer, alarmLed, compressorLed;
  logic powerLed;
  logic [2:0] seenPrev = 3'h0;
  logic [2:0] expQ[$];
  int err_total = 0;
  int n_compared = 0;
  int gates = 0;
  int tv[6] = '{100, 120, 50, 10, 0, 50};
  logic [2:0] ev[6] = '{3'h4, 3'h7, 3'h4, 3'h0, 3'h3, 3'h0};
  always #10 clk = ~clk;
  always begin
    repeat (9) @(posedge clk);
    #2 timeTick = 1'b1;
    @(posedge clk);
    #2 timeTick = 1'b0;
  end
  fridge_compressor_control #(.START_CYC(TB_START), .GATE_CYC(4),
    .DOOR_TICKS(5))
    i_dut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .timeTick(timeTick),
    .airTemp(airTemp), .airTempValid(airTempValid), .zeroCross(zeroCross),
    .doorOpen(doorOpen), .relayOn(relayOn), .triacGate(triacGate),
    .buzzer(buzzer), .alarmLed(alarmLed), .compressorLed(compressorLed),
    .powerLed(powerLed));
  zero_cross_src #(.HALF(TB_HALF)) i_mains (.clk(clk), .zeroCross(zeroCross));
  // ********************************************************
  // checking
  // ********************************************************
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  // an unexpected output change meets an empty queue and fails
  always @(negedge clk) begin
    if ({relayOn, alarmLed, buzzer} !== seenPrev) begin
      seenPrev = {relayOn, alarmLed, buzzer};
      check(seenPrev, expQ.size() > 0 ? expQ.pop_front() : 3'hX);
    end
  end
  always @(posedge triacGate) gates++;
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ********************************************************
  // stimulus
  // ********************************************************
  task automatic settle(input string name);
    repeat (400) begin
      @(posedge clk);
      if (expQ.size() == 0) break;
    end
    repeat (10) @(posedge clk);
    check(3'(expQ.size()), 3'h0);
    $display("done %s", name);
  endtask
  task automatic sample(input int t);
    @(posedge clk);
    #2 airTemp = temp_t'(t);
    airTempValid = 1'b1;
    @(posedge clk);
    #2 airTempValid = 1'b0;
  endtask
  task automatic set_door(input logic v);
    @(posedge clk);
    #2 doorOpen = v;
  endtask
  task automatic door_test(input logic [2:0] e);
    set_door(1'b1);
    repeat (3) @(posedge timeTick);
    set_door(1'b0);
    repeat (20) @(posedge clk);
    expQ.push_back(e);
    set_door(1'b1);
    repeat (3) @(posedge timeTick);
    check(3'(expQ.size()), 3'h1);
    settle("door open");
    expQ.push_back(3'h0);
    set_door(1'b0);
    settle("door closed");
  endtask
  initial begin
    void'($urandom(82));
    repeat (20) @(posedge clk);
    #2 nrst = 1'b1;
    repeat (2) @(posedge clk);
    check({2'b00, powerLed}, 3'h1);
    // a conversion offered while frozen must be lost
    #2 clkEn = 1'b0;
    sample(int'(ALARM_MAX) + $urandom_range(50));
    repeat (20) @(posedge clk);
    #2 clkEn = 1'b1;
    repeat (10) @(posedge clk);
    check({relayOn, alarmLed, buzzer}, 3'h0);
    $display("done clock enable");
    door_test(3'h2);
    for (int k = 0; k < 2; k++) begin
      gates = 0;
      expQ.push_back(3'h4);
      sample(int'(RANGE_MAX) + $urandom_range(39));
      repeat (600) @(posedge clk);
      check(gates < 8 ? 3'(gates) : 3'h0, 3'(EXP_GATES));
      sample(int'(RANGE_MIN) + 1 + $urandom_range(58));
      expQ.push_back(3'h0);
      sample(int'(RANGE_MIN));
      settle("start and stop");
    end
    tv[1] += $urandom_range(50);
    tv[4] -= $urandom_range(50);
    for (int i = 0; i < 6; i++) begin
      expQ.push_back(ev[i]);
      sample(tv[i]);
      settle("alarm level");
    end
    door_test(3'h3);
    wrap_up();
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
